/* rtl/ipf_top.sv */
// Implementation choices: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ns
`default_nettype none
module ipf_top (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_b_i,
  // axi4-lite write address
  input  wire logic [31:0] s_axi_awaddr_i,
  input  wire logic        s_axi_awvalid_i,
  output logic             s_axi_awready_o,
  // axi4-lite write data
  input  wire logic [31:0] s_axi_wdata_i,
  input  wire logic [3:0]  s_axi_wstrb_i,
  input  wire logic        s_axi_wvalid_i,
  output logic             s_axi_wready_o,
  // axi4-lite write response
  output logic [1:0]       s_axi_bresp_o,
  output logic             s_axi_bvalid_o,
  input  wire logic        s_axi_bready_i,
  // axi4-lite read address
  input  wire logic [31:0] s_axi_araddr_i,
  input  wire logic        s_axi_arvalid_i,
  output logic             s_axi_arready_o,
  // axi4-lite read data
  output logic [31:0]      s_axi_rdata_o,
  output logic [1:0]       s_axi_rresp_o,
  output logic             s_axi_rvalid_o,
  input  wire logic        s_axi_rready_i,
  // priority levels toward arbitration
  output logic [2:0]       serial_event_level_o,
  output logic [2:0]       serial_fault_level_o,
  output logic [2:0]       capture_five_level_o,
  output logic [2:0]       capture_four_level_o,
  output logic [2:0]       capture_three_level_o,
  // per-source enable, low when the field is zero
  output logic [4:0]       source_enable_o
);

  logic [15:0] serial_source_priority_register_r;
  logic [15:0] capture_source_priority_register_r;
  logic [31:0] awaddr_r;
  logic        aw_held_r;
  logic [31:0] wdata_r;
  logic [3:0]  wstrb_r;
  logic        w_held_r;
  logic        bvalid_r;
  logic [1:0]  bresp_r;
  logic        rvalid_r;
  logic [1:0]  rresp_r;
  logic [31:0] rdata_r;
  logic        wr_go;
  logic [15:0] wr_val;

  // 0 = serial, 1 = capture, 2 = unmapped
  function automatic logic [1:0] decode(input logic [31:0] a);
    if (a[31:4] != 28'h0) begin
      decode = 2'h2;
    end else if (a[3:0] == ipf_pkg::SERIAL_PRIO_OFS) begin
      decode = 2'h0;
    end else if (a[3:0] == ipf_pkg::CAPTURE_PRIO_OFS) begin
      decode = 2'h1;
    end else begin
      decode = 2'h2;
    end
  endfunction : decode

  // address and data are caught independently, so either may come first
  assign s_axi_awready_o = !aw_held_r && !bvalid_r;
  assign s_axi_wready_o  = !w_held_r && !bvalid_r;
  assign wr_go           = aw_held_r && w_held_r && !bvalid_r;

  always_comb begin
    wr_val = 16'h0;
    wr_val[7:0]  = wdata_r[7:0];
    wr_val[15:8] = wdata_r[15:8];
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      aw_held_r <= 1'b0;
      awaddr_r  <= 32'h0;
    end else if (s_axi_awvalid_i && s_axi_awready_o) begin
      aw_held_r <= 1'b1;
      awaddr_r  <= s_axi_awaddr_i;
    end else if (wr_go) begin
      aw_held_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      w_held_r <= 1'b0;
      wdata_r  <= 32'h0;
      wstrb_r  <= 4'h0;
    end else if (s_axi_wvalid_i && s_axi_wready_o) begin
      w_held_r <= 1'b1;
      wdata_r  <= s_axi_wdata_i;
      wstrb_r  <= s_axi_wstrb_i;
    end else if (wr_go) begin
      w_held_r <= 1'b0;
    end
  end

  // only implemented bits are stored, per byte lane
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      serial_source_priority_register_r  <= ipf_pkg::SERIAL_RESET;
      capture_source_priority_register_r <= ipf_pkg::CAPTURE_RESET;
    end else if (wr_go) begin
      if (decode(awaddr_r) == 2'h0 && wstrb_r[0]) begin
        serial_source_priority_register_r[7:0] <=
          wr_val[7:0] & ipf_pkg::SERIAL_MASK[7:0];
      end
      if (decode(awaddr_r) == 2'h1) begin
        if (wstrb_r[0]) begin
          capture_source_priority_register_r[7:0] <=
            wr_val[7:0] & ipf_pkg::CAPTURE_MASK[7:0];
        end
        if (wstrb_r[1]) begin
          capture_source_priority_register_r[15:8] <=
            wr_val[15:8] & ipf_pkg::CAPTURE_MASK[15:8];
        end
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      bvalid_r <= 1'b0;
      bresp_r  <= ipf_pkg::RESP_OKAY;
    end else if (wr_go) begin
      bvalid_r <= 1'b1;
      bresp_r  <= (decode(awaddr_r) == 2'h2) ? ipf_pkg::RESP_SLVERR : ipf_pkg::RESP_OKAY;
    end else if (bvalid_r && s_axi_bready_i) begin
      bvalid_r <= 1'b0;
    end
  end

  assign s_axi_bvalid_o  = bvalid_r;
  assign s_axi_bresp_o   = bresp_r;
  assign s_axi_arready_o = !rvalid_r;

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rvalid_r <= 1'b0;
      rresp_r  <= ipf_pkg::RESP_OKAY;
      rdata_r  <= 32'h0;
    end else if (s_axi_arvalid_i && s_axi_arready_o) begin
      rvalid_r <= 1'b1;
      if (decode(s_axi_araddr_i) == 2'h0) begin
        rdata_r <= {16'h0, serial_source_priority_register_r & ipf_pkg::SERIAL_MASK};
        rresp_r <= ipf_pkg::RESP_OKAY;
      end else if (decode(s_axi_araddr_i) == 2'h1) begin
        rdata_r <= {16'h0, capture_source_priority_register_r & ipf_pkg::CAPTURE_MASK};
        rresp_r <= ipf_pkg::RESP_OKAY;
      end else begin
        rdata_r <= 32'h0;
        rresp_r <= ipf_pkg::RESP_SLVERR;
      end
    end else if (rvalid_r && s_axi_rready_i) begin
      rvalid_r <= 1'b0;
    end
  end

  assign s_axi_rvalid_o = rvalid_r;
  assign s_axi_rresp_o  = rresp_r;
  assign s_axi_rdata_o  = rdata_r;

  logic [14:0] fields;
  logic [14:0] levels;
  assign fields = {
    serial_source_priority_register_r[ipf_pkg::SER_EVENT_LSB +: 3],
    serial_source_priority_register_r[ipf_pkg::SER_FAULT_LSB +: 3],
    capture_source_priority_register_r[ipf_pkg::CAP_FIVE_LSB +: 3],
    capture_source_priority_register_r[ipf_pkg::CAP_FOUR_LSB +: 3],
    capture_source_priority_register_r[ipf_pkg::CAP_THREE_LSB +: 3]};

  genvar g;
  generate
    for (g = 0; g < 5; g++) begin : g_dec
      ipf_level_decode u_dec (
        .field_i   (fields[g*3 +: 3]),
        .level_o   (levels[g*3 +: 3]),
        .enabled_o (source_enable_o[g])
      );
    end
  endgenerate

  assign serial_event_level_o  = levels[14:12];
  assign serial_fault_level_o  = levels[11:9];
  assign capture_five_level_o  = levels[8:6];
  assign capture_four_level_o  = levels[5:3];
  assign capture_three_level_o = levels[2:0];

  property p_top_level;
    @(posedge clk_i) disable iff (!rst_b_i)
      (capture_five_level_o == 3'h7) |->
        source_enable_o[2] && capture_source_priority_register_r[14:12] == 3'h7;
  endproperty
  a_top_level: assert property (p_top_level) else $error("level seven mismatch");

  property p_low_level;
    @(posedge clk_i) disable iff (!rst_b_i)
      (serial_fault_level_o == serial_source_priority_register_r[2:0]);
  endproperty
  a_low_level: assert property (p_low_level) else $error("fault level mismatch");

  property p_disable;
    @(posedge clk_i) disable iff (!rst_b_i)
      (serial_source_priority_register_r[6:4] == 3'h0) |-> !source_enable_o[4];
  endproperty
  a_disable: assert property (p_disable) else $error("zero field not disabled");

  property p_five_pos;
    @(posedge clk_i) disable iff (!rst_b_i)
      capture_five_level_o == capture_source_priority_register_r[14:12];
  endproperty
  a_five_pos: assert property (p_five_pos) else $error("channel five field misplaced");

  property p_four_pos;
    @(posedge clk_i) disable iff (!rst_b_i)
      capture_four_level_o == capture_source_priority_register_r[10:8];
  endproperty
  a_four_pos: assert property (p_four_pos) else $error("channel four field misplaced");

  property p_three_pos;
    @(posedge clk_i) disable iff (!rst_b_i)
      capture_three_level_o == capture_source_priority_register_r[6:4];
  endproperty
  a_three_pos: assert property (p_three_pos) else $error("channel three field misplaced");

  property p_cap_zero;
    @(posedge clk_i) disable iff (!rst_b_i)
      (capture_source_priority_register_r & 16'h880f) == 16'h0;
  endproperty
  a_cap_zero: assert property (p_cap_zero) else $error("capture reserved bit set");

  sequence s_wr;
    wr_go && decode(awaddr_r) == 2'h0 && wstrb_r[0];
  endsequence
  property p_wr_serial;
    @(posedge clk_i) disable iff (!rst_b_i)
      s_wr |=> serial_source_priority_register_r == ($past(wdata_r[15:0]) & 16'h0077);
  endproperty
  a_wr_serial: assert property (p_wr_serial) else $error("serial write lost");

  property p_ser_zero;
    @(posedge clk_i) disable iff (!rst_b_i)
      (serial_source_priority_register_r & 16'hff88) == 16'h0;
  endproperty
  a_ser_zero: assert property (p_ser_zero) else $error("serial reserved bit set");

endmodule : ipf_top
`default_nettype wire

/* common/ipf_pkg.sv */
`default_nettype none
package ipf_pkg;
  // register byte addresses on the bus
  localparam logic [3:0] SERIAL_PRIO_OFS  = 4'h0;
  localparam logic [3:0] CAPTURE_PRIO_OFS = 4'h4;
  // field positions (low bit of each 3-bit field)
  localparam int SER_EVENT_LSB  = 4;
  localparam int SER_FAULT_LSB  = 0;
  localparam int CAP_FIVE_LSB   = 12;
  localparam int CAP_FOUR_LSB   = 8;
  localparam int CAP_THREE_LSB  = 4;
  // implemented-bit masks
  localparam logic [15:0] SERIAL_MASK  = 16'h0077;
  localparam logic [15:0] CAPTURE_MASK = 16'h7770;
  // value after reset: level four in each field
  localparam logic [2:0]  FIELD_RESET  = 3'h4;
  localparam logic [15:0] SERIAL_RESET  = 16'h0044;
  localparam logic [15:0] CAPTURE_RESET = 16'h4440;
  // axi response codes
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : ipf_pkg
`default_nettype wire

/* rtl/ipf_level_decode.sv */
`timescale 1ns/1ns
`default_nettype none
module ipf_level_decode (
  // field in
  input  wire logic [2:0] field_i,
  // decoded level
  output logic      [2:0] level_o,
  output logic            enabled_o
);
  // codes map straight onto levels, zero means the source is off
  assign level_o   = field_i;
  assign enabled_o = (field_i != 3'h0);
endmodule : ipf_level_decode
`default_nettype wire

/* tb/ipf_tb.sv */
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic        clk_i, rst_b_i;
  logic [31:0] awaddr, wdata, araddr, rdata, got;
  logic [3:0]  wstrb;
  logic        awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp, gresp;
  logic [2:0]  lv_se, lv_sf, lv_c5, lv_c4, lv_c3, k, j;
  logic [4:0]  en;
  int          bad_count, check_count, cyc;

  ipf_top DUT (
    .clk_i(clk_i), .rst_b_i(rst_b_i),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
    .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
    .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
    .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
    .serial_event_level_o(lv_se), .serial_fault_level_o(lv_sf),
    .capture_five_level_o(lv_c5), .capture_four_level_o(lv_c4),
    .capture_three_level_o(lv_c3), .source_enable_o(en)
  );

  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : print_verdict

  // cut a hung handshake short
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      bad_count++;
      $display("CHECK FAILED t=%0t timeout", $time);
      print_verdict;
    end
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    check_count++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, g, e);
    end
  endtask : chk

  // readies are combinational and stable mid-cycle, so the negedge sample
  // equals what the slave sees at the next rising edge
  task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [3:0] s,
                    input logic [1:0] er);
    logic aw_hs, w_hs, done;
    done = 1'b0;
    @(posedge clk_i);
    awaddr  <= a;
    wdata   <= d;
    wstrb   <= s;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    while (!done) begin
      @(negedge clk_i);
      aw_hs = awvalid & awready;
      w_hs  = wvalid & wready;
      done  = bvalid;
      gresp = bresp;
      @(posedge clk_i);
      if (aw_hs) awvalid <= 1'b0;
      if (w_hs) wvalid <= 1'b0;
      if (done) bready <= 1'b0;
    end
    chk({30'h0, gresp}, {30'h0, er}, "bresp");
  endtask : wr

  task automatic rd(input logic [31:0] a, input logic [31:0] e, input logic [1:0] er);
    logic ar_hs, done;
    done = 1'b0;
    @(posedge clk_i);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    while (!done) begin
      @(negedge clk_i);
      ar_hs = arvalid & arready;
      done  = rvalid;
      got   = rdata;
      gresp = rresp;
      @(posedge clk_i);
      if (ar_hs) arvalid <= 1'b0;
      if (done) rready <= 1'b0;
    end
    chk(got, e, "rdata");
    chk({30'h0, gresp}, {30'h0, er}, "rresp");
  endtask : rd

  task automatic lv(input logic [2:0] a, b, c, d, f);
    chk({17'h0, lv_se, lv_sf, lv_c5, lv_c4, lv_c3}, {17'h0, a, b, c, d, f}, "levels");
    chk({27'h0, en}, {27'h0, a != 0, b != 0, c != 0, d != 0, f != 0}, "enables");
  endtask : lv

  initial begin
    rst_b_i = 1'b0;
    {awaddr, wdata, araddr, wstrb} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    bad_count = 0;
    check_count = 0;
    cyc = 0;
    repeat (12) @(posedge clk_i);
    rst_b_i <= 1'b1;
    rd(32'h0, 32'h44, ipf_pkg::RESP_OKAY); // serial reset value
    rd(32'h4, 32'h4440, ipf_pkg::RESP_OKAY); // capture reset value
    lv(3'h4, 3'h4, 3'h4, 3'h4, 3'h4); // levels after reset
    $display("test reset done");
    wr(32'h0, 32'hffffffff, 4'hf, ipf_pkg::RESP_OKAY); // all ones
    wr(32'h4, 32'hffffffff, 4'hf, ipf_pkg::RESP_OKAY); // all ones
    rd(32'h0, 32'h77, ipf_pkg::RESP_OKAY); // only fields kept
    rd(32'h4, 32'h7770, ipf_pkg::RESP_OKAY); // only fields kept
    $display("test reserved bits done");
    // every code in every field, neighbours opposite so a shifted field shows
    for (int c = 0; c < 8; c++) begin
      k = c[2:0];
      j = 3'h7 - k;
      wr(32'h0, {25'h0, k, 1'b0, j}, 4'hf, ipf_pkg::RESP_OKAY); // field places
      wr(32'h4, {17'h0, k, 1'b0, j, 1'b0, k, 4'h0}, 4'hf, ipf_pkg::RESP_OKAY);
      lv(k, j, k, j, k); // level and enable per code
      rd(32'h4, {17'h0, k, 1'b0, j, 1'b0, k, 4'h0}, ipf_pkg::RESP_OKAY); // readback
    end
    $display("test codes done");
    wr(32'h0, 32'hffffffff, 4'h2, ipf_pkg::RESP_OKAY); // upper byte only
    rd(32'h0, 32'h70, ipf_pkg::RESP_OKAY); // fields unchanged
    wr(32'h8, 32'hffffffff, 4'hf, ipf_pkg::RESP_SLVERR); // unmapped write
    rd(32'h8, 32'h0, ipf_pkg::RESP_SLVERR); // unmapped read
    rd(32'h4, 32'h7070, ipf_pkg::RESP_OKAY); // no side effect
    lv(3'h7, 3'h0, 3'h7, 3'h0, 3'h7); // top and disabled
    wr(32'h4, 32'h0, 4'h1, ipf_pkg::RESP_OKAY); // low lane only
    rd(32'h4, 32'h7000, ipf_pkg::RESP_OKAY); // high lane kept
    lv(3'h7, 3'h0, 3'h7, 3'h0, 3'h0); // channel three now off
    rd(32'h10, 32'h0, ipf_pkg::RESP_SLVERR); // address above the map
    $display("test strobe and unmapped done");
    print_verdict;
  end
endmodule : tb
`default_nettype wire
